/* File: dets_regs.svh */
// Register offsets, field positions and reset values of the trigger block
// How it works
// - Mode bits decode to off, edge, level, latched, FIFO
// - Any mode but off turns second irq pin into input
// - Gyro always affected; accel when extension set
// - Trigger active low unless polarity bit set
// - Edge mode keeps first sample after active edge
// - Without extension accel keeps its own rate
// - With extension accel downsampled by same trigger
// - Level sampled at tick; later change waits
// - Unbatched gyro leaves FIFO accel traffic normal; code gates FIFO accel by the extension bit alone, whatever the gyro batching
// - Level mode stamps active level into LSB
// - Level mode keeps every sample, normal batching
// - Gated data-ready only while trigger active, in level mode only
// - Data-ready output latched or pulsed by bit
// - Latched mode stamps one after a pulse
// - FIFO-enable mode batches only while active
// - FIFO-enable stamps 0 odd, 1 even windows
// - Axis and sensor bits pick stamped LSBs
`ifndef DETS_REGS_SVH
`define DETS_REGS_SVH

`define DETS_OFS_MODE      8'h00
`define DETS_OFS_STAMP     8'h01
`define DETS_OFS_ROUTE     8'h02
`define DETS_OFS_STATUS    8'h03

`define DETS_MODE_EDGE_BIT 2
`define DETS_MODE_LVL1_BIT 1
`define DETS_MODE_LVL2_BIT 0

`define DETS_STAMP_AXIS_LO 0
`define DETS_STAMP_AXIS_HI 2
`define DETS_STAMP_SEL_BIT 3
`define DETS_STAMP_EXT_BIT 4
`define DETS_STAMP_POL_BIT 5

`define DETS_ROUTE_GATE_BIT  0
`define DETS_ROUTE_PULSE_BIT 1

`define DETS_RST_MODE      3'h0
`define DETS_RST_STAMP     6'h07
`define DETS_RST_ROUTE     2'h0

`define DETS_GYRO          0
`define DETS_ACCEL         1

`endif

/* File: dets_pkg.sv */
// Types shared by the trigger block and its per-sensor path
package dets_pkg;

  typedef enum logic [2:0] {
    DETS_OFF,
    DETS_EDGE,
    DETS_LEVEL,
    DETS_LATCHED,
    DETS_FIFO_EN
  } dets_mode_t;

  typedef logic [15:0] dets_word_t;
  typedef dets_word_t [2:0] dets_axes_t;

  typedef struct packed {
    logic       sensor;
    dets_axes_t axes;
  } dets_fifo_t;

  typedef struct packed {
    logic       pol;
    logic       ext;
    logic       sel;
    logic [2:0] axis;
  } dets_stamp_cfg_t;

  typedef struct packed {
    logic pulse;
    logic gate;
  } dets_route_t;

endpackage

/* File: dets_path.sv */
// One sensor's sample path: downsampling, stamping, ready flag, batching
`timescale 1ns/100ps
module dets_path (
  input  wire logic                  core_clk,
  input  wire logic                  rst_b,
  input  wire logic                  odr_tick,
  input  wire dets_pkg::dets_axes_t  sample,
  input  wire logic                  den_active,
  input  wire logic                  den_edge,
  input  wire logic                  mode_new,
  input  wire dets_pkg::dets_mode_t  mode,
  input  wire logic                  apply_den,
  input  wire logic [2:0]            stamp_mask,
  input  wire logic                  batch_enable,
  input  wire logic                  ready_clear,
  output dets_pkg::dets_axes_t       out_data,
  output logic                       data_ready,
  output logic                       update_pulse,
  output logic                       fifo_valid,
  output logic                       window_odd
);

  logic                 prev_q, prev_d;
  logic                 pend_q, pend_d;
  logic                 odd_q, odd_d;
  logic                 rdy_q, rdy_d;
  logic                 upd_q, upd_d;
  logic                 fv_q, fv_d;
  dets_pkg::dets_axes_t out_q, out_d;
  dets_pkg::dets_axes_t stamped;
  logic                 rise, take, sbit, do_stamp;

  // Next state of the path; the level is only looked at on the tick
  always_comb
  begin
    rise   = odr_tick & den_active & ~prev_q;
    prev_d = odr_tick ? den_active : prev_q;
    pend_d = pend_q;
    if (odr_tick)
      pend_d = 1'b0;
    if (den_edge)
      pend_d = 1'b1;                                         // Set wins
    odd_d = odd_q;
    if (mode == dets_pkg::DETS_FIFO_EN && rise)
      odd_d = ~odd_q;
    if (mode_new)
      odd_d = 1'b0;
    sbit     = 1'b0;
    do_stamp = 1'b1;
    unique case (mode)
      dets_pkg::DETS_LEVEL:   sbit = den_active;
      dets_pkg::DETS_LATCHED: sbit = pend_q | den_edge;
      dets_pkg::DETS_FIFO_EN: sbit = ~(odd_q ^ rise);
      dets_pkg::DETS_OFF,
      dets_pkg::DETS_EDGE:    do_stamp = 1'b0;
    endcase
    // Where the trigger applies, edge mode drops all samples but the first after an edge
    take = odr_tick & (!(apply_den && mode == dets_pkg::DETS_EDGE)
                       || rise);
    stamped = sample;
    for (int i = 0; i < 3; i++)
      if (do_stamp && stamp_mask[i])
        stamped[i][0] = sbit;
    out_d = take ? stamped : out_q;
    upd_d = take;
    rdy_d = rdy_q;
    if (ready_clear)
      rdy_d = 1'b0;
    if (take)
      rdy_d = 1'b1;                                          // Set wins
    // Where the trigger applies, FIFO-enable mode holds back batching outside the window
    fv_d = take & batch_enable
         & (!(apply_den && mode == dets_pkg::DETS_FIFO_EN)
            || den_active);
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prev_q <= 1'b0;
      pend_q <= 1'b0;
      odd_q  <= 1'b0;
      rdy_q  <= 1'b0;
      upd_q  <= 1'b0;
      fv_q   <= 1'b0;
      out_q  <= '0;
    end
    else
    begin
      prev_q <= prev_d;
      pend_q <= pend_d;
      odd_q  <= odd_d;
      rdy_q  <= rdy_d;
      upd_q  <= upd_d;
      fv_q   <= fv_d;
      out_q  <= out_d;
    end
  end

  assign out_data     = out_q;
  assign data_ready   = rdy_q;
  assign update_pulse = upd_q;
  assign fifo_valid   = fv_q;
  assign window_odd   = odd_q;

  // Checks share the core clock and rest while reset is held
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  edge_drop_a: assert property (
    (odr_tick && apply_den && mode == dets_pkg::DETS_EDGE
     && !(den_active && !prev_q)) |=> !update_pulse)
    else $error("Edge mode kept a sample without an edge");

  level_stamp_a: assert property (
    (odr_tick && mode == dets_pkg::DETS_LEVEL && stamp_mask[0])
    |=> out_data[0][0] == $past(den_active))
    else $error("Level stamp does not follow trigger level");

  fifo_gate_a: assert property (
    (odr_tick && apply_den && mode == dets_pkg::DETS_FIFO_EN
     && !den_active) |=> !fifo_valid)
    else $error("Batched outside the trigger window");

  level_batch_a: assert property (
    (odr_tick && mode == dets_pkg::DETS_LEVEL && batch_enable)
    |=> fifo_valid && update_pulse)
    else $error("Level mode lost a sample");

  latch_zero_a: assert property (
    (odr_tick && mode == dets_pkg::DETS_LATCHED && stamp_mask[0]
     && !pend_q && !den_edge) |=> out_data[0][0] == 1'b0)
    else $error("Latched stamp set without a pulse");

  window_clear_a: assert property (
    mode_new |=> !window_odd ##1 (!window_odd || $past(rise)))
    else $error("Window count not cleared on new mode");

endmodule

/* File: dets_core.sv */
// Data-enable trigger logic: registers, pin handling, two sensor paths
`timescale 1ns/100ps
`include "dets_regs.svh"
module dets_core (
  input  wire logic                       core_clk,
  input  wire logic                       rst_b,
  input  wire logic [7:0]                 reg_addr,
  input  wire logic [7:0]                 reg_wdata,
  input  wire logic                       reg_write,
  input  wire logic                       reg_read,
  output logic [7:0]                      reg_rdata,
  input  wire logic [1:0]                 odr_tick,
  input  wire dets_pkg::dets_axes_t [1:0] sensor_sample,
  input  wire logic [1:0]                 batch_enable,
  input  wire logic                       second_irq_source,
  input  wire logic                       second_irq_pin_i,
  output logic                            second_irq_pin_o,
  output logic                            second_irq_pin_oe,
  output logic                            first_irq_pin_o,
  output dets_pkg::dets_axes_t            gyro_out,
  output dets_pkg::dets_axes_t            accel_out,
  output logic                            gyro_data_ready_flag,
  output logic                            accel_data_ready_flag,
  output logic [1:0]                      fifo_valid,
  output dets_pkg::dets_fifo_t [1:0]      fifo_data
);

  // Mode select bits to mode; the three unused codes act as off
  function automatic dets_pkg::dets_mode_t dets_decode(
    input logic [2:0] sel
  );
    dets_pkg::dets_mode_t m;
    m = dets_pkg::DETS_OFF;
    unique case (sel)
      3'h4:    m = dets_pkg::DETS_EDGE;
      3'h2:    m = dets_pkg::DETS_LEVEL;
      3'h3:    m = dets_pkg::DETS_LATCHED;
      3'h6:    m = dets_pkg::DETS_FIFO_EN;
      default: m = dets_pkg::DETS_OFF;
    endcase
    return m;
  endfunction

  // Configuration state
  logic [2:0]                trigger_mode_config_q, trigger_mode_config_d;
  logic [2:0]                mode_prev_q, mode_prev_d;
  dets_pkg::dets_stamp_cfg_t stamping_config_q, stamping_config_d;
  dets_pkg::dets_route_t     first_irq_route_config_q;
  dets_pkg::dets_route_t     first_irq_route_config_d;
  logic [7:0]                rdata_q, rdata_d;

  // Pin and trigger state
  logic                      sync1_q, sync2_q, sync3_q;
  logic                      irq1_q, irq1_d;
  logic                      oe_q, oe_d;
  logic                      pin_o_q, pin_o_d;

  // Derived signals
  dets_pkg::dets_mode_t      mode;
  logic                      mode_new;
  logic                      den_active, den_prev, den_edge;
  logic                      ready_clear;
  logic [1:0]                apply_den;
  logic [1:0][2:0]           stamp_mask;
  dets_pkg::dets_axes_t [1:0] out_data;
  logic [1:0]                data_ready, update_pulse, fifo_v, window_odd;
  logic                      drdy_evt, drdy_lvl, drdy_allow;
  logic [7:0]                status;

  assign mode     = dets_decode(trigger_mode_config_q);
  assign mode_new = (mode != dets_pkg::DETS_OFF)
                  && (mode != dets_decode(mode_prev_q));

  // Register writes; unmapped offsets and the status word ignore writes
  always_comb
  begin
    trigger_mode_config_d    = trigger_mode_config_q;
    stamping_config_d        = stamping_config_q;
    first_irq_route_config_d = first_irq_route_config_q;
    mode_prev_d              = trigger_mode_config_q;
    if (reg_write)
    begin
      unique case (reg_addr)
        `DETS_OFS_MODE:
          trigger_mode_config_d = {reg_wdata[`DETS_MODE_EDGE_BIT],
                                   reg_wdata[`DETS_MODE_LVL1_BIT],
                                   reg_wdata[`DETS_MODE_LVL2_BIT]};
        `DETS_OFS_STAMP:
          stamping_config_d = {reg_wdata[`DETS_STAMP_POL_BIT],
                               reg_wdata[`DETS_STAMP_EXT_BIT],
                               reg_wdata[`DETS_STAMP_SEL_BIT],
                               reg_wdata[`DETS_STAMP_AXIS_HI:
                                         `DETS_STAMP_AXIS_LO]};
        `DETS_OFS_ROUTE:
          first_irq_route_config_d = {reg_wdata[`DETS_ROUTE_PULSE_BIT],
                                      reg_wdata[`DETS_ROUTE_GATE_BIT]};
        default:
          trigger_mode_config_d = trigger_mode_config_q;
      endcase
    end
  end

  // Read data; one cycle after the strobe and zero otherwise
  always_comb
  begin
    status                          = 8'h00;
    status[`DETS_GYRO]              = data_ready[`DETS_GYRO];
    status[`DETS_ACCEL]             = data_ready[`DETS_ACCEL];
    status[2]                       = den_active;
    status[3]                       = window_odd[`DETS_GYRO];
    status[6:4]                     = trigger_mode_config_q;
    rdata_d = 8'h00;
    if (reg_read)
    begin
      unique case (reg_addr)
        `DETS_OFS_MODE:
        begin
          rdata_d[`DETS_MODE_EDGE_BIT] = trigger_mode_config_q[2];
          rdata_d[`DETS_MODE_LVL1_BIT] = trigger_mode_config_q[1];
          rdata_d[`DETS_MODE_LVL2_BIT] = trigger_mode_config_q[0];
        end
        `DETS_OFS_STAMP:  rdata_d = {2'h0, stamping_config_q};
        `DETS_OFS_ROUTE:  rdata_d = {6'h00, first_irq_route_config_q};
        `DETS_OFS_STATUS: rdata_d = status;
        default:          rdata_d = 8'h00;
      endcase
    end
  end

  // Reading status acknowledges both ready flags
  assign ready_clear = reg_read && (reg_addr == `DETS_OFS_STATUS);

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      trigger_mode_config_q    <= `DETS_RST_MODE;
      mode_prev_q              <= `DETS_RST_MODE;
      stamping_config_q        <= `DETS_RST_STAMP;
      first_irq_route_config_q <= `DETS_RST_ROUTE;
      rdata_q                  <= 8'h00;
    end
    else
    begin
      trigger_mode_config_q    <= trigger_mode_config_d;
      mode_prev_q              <= mode_prev_d;
      stamping_config_q        <= stamping_config_d;
      first_irq_route_config_q <= first_irq_route_config_d;
      rdata_q                  <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // Pin synchroniser; the third stage only feeds the edge detector
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end
    else
    begin
      sync1_q <= second_irq_pin_i;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Polarity correction; while off the pin is an output and is not read
  always_comb
  begin
    den_active = 1'b0;
    den_prev   = 1'b0;
    if (mode != dets_pkg::DETS_OFF)
    begin
      den_active = stamping_config_q.pol ? sync2_q : ~sync2_q;
      den_prev   = stamping_config_q.pol ? sync3_q : ~sync3_q;
    end
    den_edge = den_active & ~den_prev;
  end

  // Which sensor the trigger acts on and which axes carry the stamp
  always_comb
  begin
    apply_den[`DETS_GYRO]   = 1'b1;
    apply_den[`DETS_ACCEL]  = stamping_config_q.ext;
    stamp_mask[`DETS_GYRO]  = stamping_config_q.sel ? 3'h0
                            : stamping_config_q.axis;
    stamp_mask[`DETS_ACCEL] = stamping_config_q.sel ? stamping_config_q.axis
                            : 3'h0;
  end

  // Gyro and accel paths are identical apart from their controls
  generate
    for (genvar s = 0; s < 2; s++)
    begin : g_path
      dets_path u_path (
        .core_clk     (core_clk),
        .rst_b        (rst_b),
        .odr_tick     (odr_tick[s]),
        .sample       (sensor_sample[s]),
        .den_active   (den_active),
        .den_edge     (den_edge),
        .mode_new     (mode_new),
        .mode         (mode),
        .apply_den    (apply_den[s]),
        .stamp_mask   (stamp_mask[s]),
        .batch_enable (batch_enable[s]),
        .ready_clear  (ready_clear),
        .out_data     (out_data[s]),
        .data_ready   (data_ready[s]),
        .update_pulse (update_pulse[s]),
        .fifo_valid   (fifo_v[s]),
        .window_odd   (window_odd[s])
      );
      assign fifo_data[s] = '{sensor: 1'(s), axes: out_data[s]};
    end
  endgenerate

  assign gyro_out              = out_data[`DETS_GYRO];
  assign accel_out             = out_data[`DETS_ACCEL];
  assign gyro_data_ready_flag  = data_ready[`DETS_GYRO];
  assign accel_data_ready_flag = data_ready[`DETS_ACCEL];
  assign fifo_valid            = fifo_v;

  // Data-ready on the first pin; gating only applies in level mode
  always_comb
  begin
    drdy_evt   = |update_pulse;
    drdy_lvl   = |data_ready;
    drdy_allow = !(mode == dets_pkg::DETS_LEVEL
                   && first_irq_route_config_q.gate) || den_active;
    irq1_d     = (first_irq_route_config_q.pulse ? drdy_evt : drdy_lvl)
               & drdy_allow;
  end

  // Second pin turns input in any mode; otherwise carries its interrupt
  always_comb
  begin
    oe_d    = (mode == dets_pkg::DETS_OFF);
    pin_o_d = oe_d & second_irq_source;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irq1_q  <= 1'b0;
      oe_q    <= 1'b1;
      pin_o_q <= 1'b0;
    end
    else
    begin
      irq1_q  <= irq1_d;
      oe_q    <= oe_d;
      pin_o_q <= pin_o_d;
    end
  end

  assign first_irq_pin_o   = irq1_q;
  assign second_irq_pin_oe = oe_q;
  assign second_irq_pin_o  = pin_o_q;

  // Checks share the core clock and rest while reset is held
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  pin_input_a: assert property (
    (mode != dets_pkg::DETS_OFF) |=> !second_irq_pin_oe && !second_irq_pin_o)
    else $error("Second pin driven while a trigger mode is on");

  ready_gate_a: assert property (
    (mode == dets_pkg::DETS_LEVEL && first_irq_route_config_q.gate
     && !den_active) |=> !first_irq_pin_o)
    else $error("Data-ready shown while trigger inactive");

  // The flag is looked at one cycle on, where set wins over a read clear
  accel_rate_a: assert property (
    (odr_tick[`DETS_ACCEL] && !stamping_config_q.ext)
    |=> update_pulse[`DETS_ACCEL] && accel_data_ready_flag)
    else $error("Accel not updated at its own rate");

endmodule

/* File: dets_trig_src.sv */
// External trigger source model for the data-enable pin
`timescale 1ns/100ps
module dets_trig_src (
  input  wire logic core_clk,
  input  wire logic pin_oe,
  input  wire logic lvl_req,
  input  wire logic slow,
  output logic      drv,
  output logic      drv_en
);
  logic [2:0] dly_q;

  // Slow source lags two extra cycles, like a buffered frame sync
  always @(posedge core_clk)
  begin
    dly_q <= {dly_q[1:0], lvl_req};
  end

  // Drives only once the device has turned its pin into an input
  assign drv_en = ~pin_oe;
  assign drv    = slow ? dly_q[2] : dly_q[0];
endmodule

/* File: dets_core_tb.sv */
// Self-checking bench for the data-enable trigger block
`timescale 1ns/100ps
module dets_core_tb;
  logic                       core_clk;
  logic                       rst_b;
  logic [7:0]                 reg_addr;
  logic [7:0]                 reg_wdata;
  logic                       reg_write;
  logic                       reg_read;
  logic [7:0]                 reg_rdata;
  logic [1:0]                 odr_tick;
  dets_pkg::dets_axes_t [1:0] sensor_sample;
  logic [1:0]                 batch_enable;
  logic                       second_irq_source;
  logic                       pin_w;
  logic                       second_irq_pin_o;
  logic                       second_irq_pin_oe;
  logic                       first_irq_pin_o;
  dets_pkg::dets_axes_t       gyro_out;
  dets_pkg::dets_axes_t       accel_out;
  logic                       gyro_data_ready_flag;
  logic                       accel_data_ready_flag;
  logic [1:0]                 fifo_valid;
  dets_pkg::dets_fifo_t [1:0] fifo_data;
  logic                       lvl_req;
  logic                       slow;
  logic                       src_drv;
  logic                       src_en;
  logic                       idle_q = 1'b0;
  int                         n_fail = 0;
  int                         check_count = 0;
  int                         md, pol, ext, sel, msk, gate, pls, cur;
  int                         prv[2], cnt[2], pend[2], fl[2];
  dets_pkg::dets_axes_t       exp_o[2] = '{default: '0};

  dets_core dut (.core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .odr_tick, .sensor_sample, .batch_enable,
    .second_irq_source, .second_irq_pin_i(pin_w), .second_irq_pin_o,
    .second_irq_pin_oe, .first_irq_pin_o, .gyro_out, .accel_out,
    .gyro_data_ready_flag, .accel_data_ready_flag, .fifo_valid,
    .fifo_data);

  dets_trig_src src (.core_clk, .pin_oe(second_irq_pin_oe), .lvl_req,
    .slow, .drv(src_drv), .drv_en(src_en));

  // Undriven pin toggles so a stale level can never pass for a real one
  always @(posedge core_clk)
  begin
    idle_q <= ~idle_q;
  end
  assign pin_w = second_irq_pin_oe ? second_irq_pin_o
               : (src_en ? src_drv : idle_q);

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [63:0] got, exp, input string m);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= ad;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata, e, "register read");
    @(posedge core_clk); // Later stimulus then starts on an edge
  endtask

  // One tick; the pin moves at the same edge, so the old level counts
  task automatic tick(input logic [1:0] tm, input int nl, input bit ck);
    int a;
    int up[2];
    logic [1:0] fv;
    dets_pkg::dets_axes_t smp[2];
    a = pol ? cur : !cur;
    fv = 2'h0;
    up = '{0, 0};
    @(posedge core_clk);
    for (int s = 0; s < 2; s++)
    begin
      smp[s] = 48'({$urandom, $urandom});
      if (tm[s])
      begin
        up[s] = !(md == 1 && (s == 0 || ext) && !(a && !prv[s]));
        cnt[s] += a && !prv[s];
        prv[s] = a;
        if (up[s])
        begin
          exp_o[s] = smp[s];
          fl[s] = 1;
          for (int i = 0; i < 3; i++)
            if (md >= 2 && sel == s && msk[i])
              exp_o[s][i][0] = md == 2 ? a[0]
                : (md == 3 ? pend[s][0] : !cnt[s][0]);
        end
        pend[s] = 0;
        fv[s] = up[s] && batch_enable[s]
          && !(md == 4 && (s == 0 || ext) && !a);
      end
    end
    sensor_sample <= {smp[1], smp[0]};
    odr_tick <= tm;
    lvl_req <= nl[0];
    @(posedge core_clk);
    odr_tick <= 2'h0;
    #1;
    if (ck)
    begin
      chk(gyro_out, exp_o[0], "gyro data");
      chk(accel_out, exp_o[1], "accel data");
      chk({gyro_data_ready_flag, accel_data_ready_flag},
          {fl[0][0], fl[1][0]}, "ready flags");
      chk(fifo_valid, fv, "fifo strobe");
      for (int s = 0; s < 2; s++)
        if (fv[s])
          chk(fifo_data[s], {s[0], exp_o[s]}, "fifo word");
    end
    @(posedge core_clk);
    #1;
    if (ck && (nl == cur || !(md == 2 && gate)))
      chk(first_irq_pin_o, (md != 2 || !gate || a) && (pls ?
          up[0] || up[1] : fl[0] || fl[1]), "ready pin");
    repeat (5) @(posedge core_clk);
    cur = nl;
  endtask

  // Reprogram, then one unchecked idle tick so edge history is known
  task automatic cfg(input logic [2:0] c, input logic [5:0] st,
                     input logic [1:0] rt);
    wr(8'h01, {2'h0, st});
    wr(8'h00, 8'h00);
    pol = st[5];
    ext = st[4];
    sel = st[3];
    msk = st[2:0];
    gate = rt[0];
    pls = rt[1];
    md = c == 4 ? 1 : c == 2 ? 2 : c == 3 ? 3 : c == 6 ? 4 : 0;
    cur = !pol;
    lvl_req <= !pol;
    wr(8'h02, {6'h0, rt});
    wr(8'h00, {5'h0, c});
    cnt = '{0, 0};
    repeat (6) @(posedge core_clk);
    tick(2'h3, cur, 0);
    rd(8'h03, {1'b0, c, 2'h0, fl[1][0], fl[0][0]});
    fl = '{0, 0};
  endtask

  // Short active pulse on the pin between two ticks
  task automatic den_pulse();
    @(posedge core_clk);
    lvl_req <= pol[0];
    repeat (3) @(posedge core_clk);
    lvl_req <= !pol;
    pend = '{1, 1};
    repeat (8) @(posedge core_clk);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // About five times the expected run length
  initial
  begin
    repeat (6000) @(posedge core_clk);
    n_fail++;
    $display("wrong value at %0t: watchdog expired", $time);
    tally_and_finish();
  end

  initial
  begin
    rst_b = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    odr_tick = 2'h0;
    sensor_sample = '0;
    batch_enable = 2'h3;
    second_irq_source = 1'b0;
    lvl_req = 1'b1;
    slow = 1'b0;
    void'($urandom(32'h7200));
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h07);
    rd(8'h02, 8'h00);
    wr(8'h10, 8'h5A);
    rd(8'h10, 8'h00);
    second_irq_source <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    chk(second_irq_pin_o, 1, "idle pin drive");
    $display("test reset done");
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h00, 8'(c));
      rd(8'h00, 8'(c));
      chk(second_irq_pin_oe, !(c inside {2, 3, 4, 6}), "pin dir");
    end
    $display("test modes done");
    for (int p = 0; p < 4; p++)
    begin
      batch_enable <= 2'($urandom);
      cfg(3'h2, {p[0], 1'b0, p[1], 3'($urandom)}, 2'h2);
      repeat (8) tick(2'h3, $urandom % 2, 1);
    end
    $display("test level done");
    for (int p = 0; p < 4; p++)
    begin
      slow <= p[0];
      batch_enable <= {1'b1, p[1]};
      cfg(3'h4, {p[0], p[1], 1'b0, 3'h7}, 2'h2);
      repeat (10) tick(2'h3, $urandom % 2, 1);
    end
    slow <= 1'b0;
    $display("test edge done");
    cfg(3'h3, 6'h05, 2'h0);
    for (int k = 0; k < 2; k++)
    begin
      den_pulse();
      tick(2'h1, cur, 1);
      tick(2'h1, cur, 1);
    end
    $display("test latched done");
    batch_enable <= 2'h1;
    for (int k = 0; k < 2; k++)
    begin
      cfg(3'h6, 6'h23, 2'h2);
      for (int i = 0; i < 8; i++)
        tick(2'h1, 8'h5A >> i & 1, 1);
      rd(8'h03, {1'b0, 3'h6, cnt[0][0], cur[0],
                 fl[1][0], fl[0][0]});
      fl = '{0, 0};
    end
    $display("test fifo window done");
    for (int p = 0; p < 2; p++)
    begin
      cfg(3'h2, 6'h01, {p[0], 1'b1});
      for (int i = 0; i < 6; i++)
        tick(2'h3, i / 2 % 2, 1);
    end
    $display("test gating done");
    tally_and_finish();
  end
endmodule
